/* File: core/timer_cfg_pkg.sv */
// Package: register map, field layout and filter tables of the channel-mode block
package timer_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int TRIG_W = 3;
  localparam int NCH = 3;
  localparam logic [ADDR_W-1:0] OFF_CM1 = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CM2 = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_CHEN = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_TRIG = 4'h3;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  // Channel indices inside per-channel vectors
  localparam int CH1 = 0;
  localparam int CH3 = 1;
  localparam int CH4 = 2;
  // Enable bit positions in the channel enable register
  localparam int CH1_EN_BIT = 0;
  localparam int CH3_EN_BIT = 8;
  localparam int CH4_EN_BIT = 12;
  // Second channel-mode register fields, and the channel 1 direction field of the first
  localparam int CH3_DIR_LO = 0;
  localparam int CH3_OIEN = 2;
  localparam int CH3_OBEN = 3;
  localparam int CH3_OCTRL_LO = 4;
  localparam int CH3_OSEN = 7;
  localparam int CH3_DIV_LO = 2;
  localparam int CH3_DF_LO = 4;
  localparam int CH4_DIR_LO = 8;
  localparam int CH4_OIEN = 10;
  localparam int CH4_OBEN = 11;
  localparam int CH4_OCTRL_LO = 12;
  localparam int CH4_OSEN = 15;
  localparam int CH4_DIV_LO = 10;
  localparam int CH4_DF_LO = 12;
  localparam int CH1_DIR_LO = 0;
  // Slave trigger select codes up to this one pick internal triggers
  localparam logic [TRIG_W-1:0] TRIG_INTERNAL_MAX = 3'h3;
  typedef enum logic [1:0] {DIR_OUTPUT, DIR_OWN, DIR_PARTNER, DIR_TRIGGER} dir_t;
  // Filter sampling divisor and sample count, indexed by filter code
  localparam logic [5:0] FILT_DIV [16] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h02, 6'h02,
    6'h04, 6'h04, 6'h08, 6'h08, 6'h10, 6'h10, 6'h10, 6'h20, 6'h20, 6'h20};
  localparam logic [3:0] FILT_N [16] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
    4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};
  localparam logic [3:0] FILT_CNT_ONE = 4'h1;
  localparam logic [5:0] PRE_ONE = 6'h01;
  localparam logic [2:0] DIV_CNT_ONE = 3'h1;
endpackage

/* File: core/input_filter.sv */
// Digital input filter: samples at a divided rate, passes an edge after N agreeing samples
`timescale 1ns/100ps
module input_filter
  import timer_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in,
  input wire logic [3:0] i_code,
  output logic o_out
);
  logic [5:0] pre;
  logic [3:0] agree;
  logic tick;

  assign tick = (pre >= FILT_DIV[i_code] - PRE_ONE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre <= 6'h00;
    end else if (tick) begin
      pre <= 6'h00;
    end else begin
      pre <= pre + PRE_ONE;
    end
  end

  // Output flips only once N consecutive samples disagree with it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      agree <= 4'h0;
      o_out <= 1'b0;
    end else if (tick) begin
      if (i_in == o_out) begin
        agree <= 4'h0;
      end else if (agree + FILT_CNT_ONE >= FILT_N[i_code]) begin
        agree <= 4'h0;
        o_out <= i_in;
      end else begin
        agree <= agree + FILT_CNT_ONE;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  filter_pass_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_out) |-> $past(tick) && $past(i_in) != $past(o_out)
      && $past(agree) + FILT_CNT_ONE >= $past(FILT_N[i_code]))
    else $error("filter output changed without enough agreeing samples");
  no_filter_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_code == 4'h0 |=> o_out == $past(i_in))
    else $error("unfiltered input not passed in one cycle");
endmodule

/* File: core/timer_channel_mode_config.sv */
// Channel-mode configuration, input routing and capture divider for channels 1, 3 and 4
//
// Overview of operation
// - Channel 1 field: output, own, ch2, trigger
// - Direction fields locked while channel enabled
// - Code 11 needs internal trigger source selected
// - Bits 1:0 select channel 3 direction
// - Bits 9:8 select channel 4 direction
// - Output layout bits 15:10 are channel 4
// - Output layout bits 7:2 are channel 3
// - Input layout: ch4 filter 15:12, divider 11:10
// - Input layout: ch3 filter 7:4, divider 3:2
// - Filter passes edge after N agreeing samples
// - Divider captures every 1, 2, 4, 8 edges
// - Divider count cleared while channel disabled
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
module timer_channel_mode_config
  import timer_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_ch1_filtered_to_ch1,
  input wire logic i_ch2_filtered_to_ch1,
  input wire logic i_ch3_raw,
  input wire logic i_ch4_raw,
  input wire logic i_internal_trigger_input,
  output logic [NCH-1:0] o_capture_input,
  output logic [NCH-1:0] o_capture,
  output logic [NCH-1:0] o_is_output,
  output logic o_ch3_output_switch_en,
  output logic [2:0] o_ch3_output_control,
  output logic o_ch3_output_buffer_en,
  output logic o_ch3_output_immediate_en,
  output logic o_ch4_output_switch_en,
  output logic [2:0] o_ch4_output_control,
  output logic o_ch4_output_buffer_en,
  output logic o_ch4_output_immediate_en
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [1:0] ch1_direction_select;
  logic [DATA_W-1:0] channel_mode_ch3_ch4;
  logic [NCH-1:0] enable_bits;
  logic [TRIG_W-1:0] slave_trigger_select;
  logic ch3_filtered_to_ch3;
  logic ch4_filtered_to_ch4;
  logic trig_ok;
  logic [NCH-1:0] sel;
  logic [NCH-1:0] rise;
  dir_t dir [NCH];
  logic [1:0] div_code [NCH];
  logic [2:0] div_cnt [NCH];
  logic [DATA_W-1:0] chen_word;
  logic wr_cm1;
  logic wr_cm2;

  assign wr_cm1 = i_wr && i_addr == OFF_CM1;
  assign wr_cm2 = i_wr && i_addr == OFF_CM2;

  function automatic logic route(input dir_t d, input logic own, input logic partner,
                                 input logic trig, input logic ok);
    logic r;
    r = 1'b0;
    unique case (d)
      DIR_OUTPUT: r = 1'b0;
      DIR_OWN: r = own;
      DIR_PARTNER: r = partner;
      DIR_TRIGGER: r = trig && ok;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] div_limit(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction

  // Direction bits accepted only while that channel is disabled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ch1_direction_select <= 2'h0;
    end else if (wr_cm1 && !enable_bits[CH1]) begin
      ch1_direction_select <= i_wdata[CH1_DIR_LO +: 2];
    end
  end

  // Other fields always writable; the same bits serve both layouts
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      channel_mode_ch3_ch4 <= REG_RESET;
    end else if (wr_cm2) begin
      channel_mode_ch3_ch4[DATA_W-1:CH4_DIR_LO+2] <= i_wdata[DATA_W-1:CH4_DIR_LO+2];
      channel_mode_ch3_ch4[CH4_DIR_LO-1:CH3_DIR_LO+2] <= i_wdata[CH4_DIR_LO-1:CH3_DIR_LO+2];
      if (!enable_bits[CH4]) begin
        channel_mode_ch3_ch4[CH4_DIR_LO +: 2] <= i_wdata[CH4_DIR_LO +: 2];
      end
      if (!enable_bits[CH3]) begin
        channel_mode_ch3_ch4[CH3_DIR_LO +: 2] <= i_wdata[CH3_DIR_LO +: 2];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_bits <= '0;
      slave_trigger_select <= '0;
    end else if (i_wr && i_addr == OFF_CHEN) begin
      enable_bits <= {i_wdata[CH4_EN_BIT], i_wdata[CH3_EN_BIT], i_wdata[CH1_EN_BIT]};
    end else if (i_wr && i_addr == OFF_TRIG) begin
      slave_trigger_select <= i_wdata[TRIG_W-1:0];
    end
  end

  always_comb begin
    chen_word = REG_RESET;
    chen_word[CH1_EN_BIT] = enable_bits[CH1];
    chen_word[CH3_EN_BIT] = enable_bits[CH3];
    chen_word[CH4_EN_BIT] = enable_bits[CH4];
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= REG_RESET;
    end else if (i_rd) begin
      unique case (i_addr)
        OFF_CM1: o_rdata <= {{(DATA_W-2){1'b0}}, ch1_direction_select};
        OFF_CM2: o_rdata <= channel_mode_ch3_ch4;
        OFF_CHEN: o_rdata <= chen_word;
        OFF_TRIG: o_rdata <= {{(DATA_W-TRIG_W){1'b0}}, slave_trigger_select};
        default: o_rdata <= REG_RESET;
      endcase
    end else begin
      o_rdata <= REG_RESET;
    end
  end

  // ----------------------------------------
  // Filters and routing
  // ----------------------------------------
  assign dir[CH1] = dir_t'(ch1_direction_select);
  assign dir[CH3] = dir_t'(channel_mode_ch3_ch4[CH3_DIR_LO +: 2]);
  assign dir[CH4] = dir_t'(channel_mode_ch3_ch4[CH4_DIR_LO +: 2]);
  // No divider field for channel 1 here, so it captures every edge
  assign div_code[CH1] = 2'h0;
  assign div_code[CH3] = channel_mode_ch3_ch4[CH3_DIV_LO +: 2];
  assign div_code[CH4] = channel_mode_ch3_ch4[CH4_DIV_LO +: 2];
  // Trigger routing is dead unless an internal source is chosen first
  assign trig_ok = slave_trigger_select <= TRIG_INTERNAL_MAX;

  input_filter ch3_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in(i_ch3_raw),
    .i_code(dir[CH3] == DIR_OUTPUT ? 4'h0 : channel_mode_ch3_ch4[CH3_DF_LO +: 4]),
    .o_out(ch3_filtered_to_ch3)
  );

  input_filter ch4_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in(i_ch4_raw),
    .i_code(dir[CH4] == DIR_OUTPUT ? 4'h0 : channel_mode_ch3_ch4[CH4_DF_LO +: 4]),
    .o_out(ch4_filtered_to_ch4)
  );

  always_comb begin
    sel[CH1] = route(dir[CH1], i_ch1_filtered_to_ch1, i_ch2_filtered_to_ch1,
                     i_internal_trigger_input, trig_ok);
    sel[CH3] = route(dir[CH3], ch3_filtered_to_ch3, ch4_filtered_to_ch4,
                     i_internal_trigger_input, trig_ok);
    sel[CH4] = route(dir[CH4], ch4_filtered_to_ch4, ch3_filtered_to_ch3,
                     i_internal_trigger_input, trig_ok);
  end

  assign rise = sel & ~o_capture_input;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_capture_input <= '0;
      o_is_output <= '0;
    end else begin
      o_capture_input <= sel;
      for (int i = 0; i < NCH; i++) begin
        o_is_output[i] <= dir[i] == DIR_OUTPUT;
      end
    end
  end

  // ----------------------------------------
  // Capture divider
  // ----------------------------------------
  // Rising edge is the active edge; polarity lives outside this block
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_capture <= '0;
      for (int i = 0; i < NCH; i++) begin
        div_cnt[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!enable_bits[i] || dir[i] == DIR_OUTPUT) begin
          div_cnt[i] <= 3'h0;
          o_capture[i] <= 1'b0;
        end else if (rise[i] && div_cnt[i] >= div_limit(div_code[i])) begin
          div_cnt[i] <= 3'h0;
          o_capture[i] <= 1'b1;
        end else if (rise[i]) begin
          div_cnt[i] <= div_cnt[i] + DIV_CNT_ONE;
          o_capture[i] <= 1'b0;
        end else begin
          o_capture[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Output-compare view
  // ----------------------------------------
  // Held at zero in input layout so the compare logic never sees filter codes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ch3_output_switch_en <= 1'b0;
      o_ch3_output_control <= 3'h0;
      o_ch3_output_buffer_en <= 1'b0;
      o_ch3_output_immediate_en <= 1'b0;
    end else begin
      o_ch3_output_switch_en <= dir[CH3] == DIR_OUTPUT && channel_mode_ch3_ch4[CH3_OSEN];
      o_ch3_output_control <= dir[CH3] == DIR_OUTPUT ?
        channel_mode_ch3_ch4[CH3_OCTRL_LO +: 3] : 3'h0;
      o_ch3_output_buffer_en <= dir[CH3] == DIR_OUTPUT && channel_mode_ch3_ch4[CH3_OBEN];
      o_ch3_output_immediate_en <= dir[CH3] == DIR_OUTPUT && channel_mode_ch3_ch4[CH3_OIEN];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ch4_output_switch_en <= 1'b0;
      o_ch4_output_control <= 3'h0;
      o_ch4_output_buffer_en <= 1'b0;
      o_ch4_output_immediate_en <= 1'b0;
    end else begin
      o_ch4_output_switch_en <= dir[CH4] == DIR_OUTPUT && channel_mode_ch3_ch4[CH4_OSEN];
      o_ch4_output_control <= dir[CH4] == DIR_OUTPUT ?
        channel_mode_ch3_ch4[CH4_OCTRL_LO +: 3] : 3'h0;
      o_ch4_output_buffer_en <= dir[CH4] == DIR_OUTPUT && channel_mode_ch3_ch4[CH4_OBEN];
      o_ch4_output_immediate_en <= dir[CH4] == DIR_OUTPUT && channel_mode_ch3_ch4[CH4_OIEN];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence cm2_write_s(logic en);
    wr_cm2 && en;
  endsequence
  sequence read_cm2_s;
    i_rd && i_addr == OFF_CM2 && !wr_cm2;
  endsequence

  dir_lock_a: assert property (cm2_write_s(enable_bits[CH3]) |=> $stable(dir[CH3]))
    else $error("ch3 direction changed while enabled");
  ch3_dir_take_a: assert property (cm2_write_s(!enable_bits[CH3]) |=>
    channel_mode_ch3_ch4[CH3_DIR_LO +: 2] == $past(i_wdata[CH3_DIR_LO +: 2]))
    else $error("ch3 direction write lost");
  ch4_dir_take_a: assert property (cm2_write_s(!enable_bits[CH4]) |=>
    channel_mode_ch3_ch4[CH4_DIR_LO +: 2] == $past(i_wdata[CH4_DIR_LO +: 2]))
    else $error("ch4 direction write lost");
  ch1_route_a: assert property (dir[CH1] == DIR_PARTNER |=>
    o_capture_input[CH1] == $past(i_ch2_filtered_to_ch1))
    else $error("ch1 not routed to ch2 input");
  trig_gate_a: assert property (dir[CH3] == DIR_TRIGGER && !trig_ok |=>
    !o_capture_input[CH3])
    else $error("trigger passed without internal source");
  ch4_oc_view_a: assert property (dir[CH4] == DIR_OUTPUT |=>
    o_ch4_output_control == $past(channel_mode_ch3_ch4[CH4_OCTRL_LO +: 3]))
    else $error("ch4 output control mismatch");
  ch3_ic_view_a: assert property (dir[CH3] != DIR_OUTPUT |=>
    o_ch3_output_control == 3'h0 && !o_ch3_output_switch_en)
    else $error("ch3 compare fields visible in input layout");
  ch3_oc_view_a: assert property (dir[CH3] == DIR_OUTPUT |=>
    o_ch3_output_buffer_en == $past(channel_mode_ch3_ch4[CH3_OBEN]))
    else $error("ch3 buffer enable mismatch");
  cm2_readback_a: assert property (read_cm2_s ##1 1'b1 |->
    o_rdata == $past(channel_mode_ch3_ch4))
    else $error("second mode register read mismatch");
  div_clear_a: assert property (!enable_bits[CH3] |=> div_cnt[CH3] == 3'h0
    && !o_capture[CH3])
    else $error("ch3 divider not cleared while disabled");
  div_every2_a: assert property (o_capture[CH3] && div_code[CH3] == 2'h1
    |-> $past(rise[CH3]) && $past(div_cnt[CH3]) == 3'h1)
    else $error("ch3 capture not on second edge");
  capture_cause_a: assert property (o_capture[CH4] |-> $past(rise[CH4])
    && $past(enable_bits[CH4]))
    else $error("ch4 capture without active edge");
endmodule

/* File: verification/timer_channel_mode_config_test.sv */
// Self-checking bench of the channel-mode configuration block
`timescale 1ns/100ps
module timer_channel_mode_config_test;
  import timer_cfg_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic i_ch1_filtered_to_ch1, i_ch2_filtered_to_ch1, i_ch3_raw, i_ch4_raw;
  logic i_internal_trigger_input;
  logic [NCH-1:0] o_capture_input, o_capture, o_is_output;
  logic o_ch3_output_switch_en, o_ch3_output_buffer_en, o_ch3_output_immediate_en;
  logic o_ch4_output_switch_en, o_ch4_output_buffer_en, o_ch4_output_immediate_en;
  logic [2:0] o_ch3_output_control, o_ch4_output_control;
  logic [5:0] cmp3, cmp4;
  logic [DATA_W-1:0] exp_q[$];
  logic rd_d1 = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int n_cap[NCH] = '{0, 0, 0};

  assign cmp3 = {o_ch3_output_switch_en, o_ch3_output_control, o_ch3_output_buffer_en,
    o_ch3_output_immediate_en};
  assign cmp4 = {o_ch4_output_switch_en, o_ch4_output_control, o_ch4_output_buffer_en,
    o_ch4_output_immediate_en};

  timer_channel_mode_config u_timer_channel_mode_config (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ch1_filtered_to_ch1(i_ch1_filtered_to_ch1),
    .i_ch2_filtered_to_ch1(i_ch2_filtered_to_ch1), .i_ch3_raw(i_ch3_raw),
    .i_ch4_raw(i_ch4_raw), .i_internal_trigger_input(i_internal_trigger_input),
    .o_capture_input(o_capture_input), .o_capture(o_capture), .o_is_output(o_is_output),
    .o_ch3_output_switch_en(o_ch3_output_switch_en),
    .o_ch3_output_control(o_ch3_output_control),
    .o_ch3_output_buffer_en(o_ch3_output_buffer_en),
    .o_ch3_output_immediate_en(o_ch3_output_immediate_en),
    .o_ch4_output_switch_en(o_ch4_output_switch_en),
    .o_ch4_output_control(o_ch4_output_control),
    .o_ch4_output_buffer_en(o_ch4_output_buffer_en),
    .o_ch4_output_immediate_en(o_ch4_output_immediate_en)
  );

  // ----------------------------------------
  // Clock, checking and bus tasks
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want,
    input string what);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t %s: saw %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Expected read data is noted here and judged by the read watcher
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  // Check on the falling edge so the rising edge's updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // Channel 1 rides along so its undivided capture path is exercised too
  task automatic pulse(input int h);
    @(posedge i_clk);
    {i_ch1_filtered_to_ch1, i_ch3_raw, i_ch4_raw} <= 3'b111;
    repeat (h) @(posedge i_clk);
    {i_ch1_filtered_to_ch1, i_ch3_raw, i_ch4_raw} <= 3'b000;
    repeat (h) @(posedge i_clk);
  endtask

  function automatic logic route(input logic [1:0] c, input logic own, input logic other,
    input logic trg, input logic [TRIG_W-1:0] sel);
    case (c)
      2'b01: return own;
      2'b10: return other;
      2'b11: return trg && (sel <= TRIG_INTERNAL_MAX);
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Watchers
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (rd_d1 && exp_q.size() > 0) begin
      check(o_rdata, exp_q.pop_front(), "read data");
    end
    rd_d1 <= i_rd;
    for (int i = 0; i < NCH; i++) begin
      if (o_capture[i] === 1'b1) begin
        n_cap[i]++;
      end
    end
  end

  // Far above the expected run length of about 2200 cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    finish_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [DATA_W-1:0] v;
    logic [TRIG_W-1:0] sel;
    logic [4:0] pins;
    int b1, b3, b4;
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_ch1_filtered_to_ch1, i_ch2_filtered_to_ch1, i_ch3_raw, i_ch4_raw} = 4'h0;
    i_internal_trigger_input = 1'b0;
    i_rst = 1'b1;
    void'($urandom(32'h8ad7));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      rd(a[ADDR_W-1:0], REG_RESET);
    end
    rd(4'hf, 16'h0000);
    wait_cyc(1);
    check(o_is_output, 3'b111, "directions after reset");
    repeat (4) begin
      v = 16'($urandom);
      v[9:8] = 2'b00;
      v[1:0] = 2'b00;
      wr(OFF_CM2, v);
      rd(OFF_CM2, v);
      wait_cyc(1);
      check(cmp4, v[15:10], "ch4 compare fields");
      check(cmp3, v[7:2], "ch3 compare fields");
    end
    wr(OFF_CM2, 16'hfdfd);
    wait_cyc(2);
    check(o_is_output, 3'b001, "input directions");
    check({cmp4, cmp3}, 12'h000, "compare fields of inputs");
    // Direction bits must hold while enabled, the rest still land
    wr(OFF_CHEN, 16'h1101);
    wr(OFF_CM2, 16'hfe02);
    rd(OFF_CM2, 16'hfd01);
    wr(OFF_CM1, 16'h0003);
    rd(OFF_CM1, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      repeat (4) begin
        sel = TRIG_W'($urandom);
        pins = 5'($urandom);
        wr(OFF_CHEN, 16'h0000);
        wr(OFF_CM1, {14'h0, c[1:0]});
        wr(OFF_CM2, {6'h00, c[1:0], 6'h00, c[1:0]});
        wr(OFF_TRIG, {13'h0, sel});
        wr(OFF_CHEN, 16'h1101);
        @(posedge i_clk);
        {i_ch1_filtered_to_ch1, i_ch2_filtered_to_ch1, i_ch3_raw, i_ch4_raw,
          i_internal_trigger_input} <= pins;
        wait_cyc(3);
        v = {13'h0, route(c[1:0], pins[1], pins[2], pins[0], sel),
          route(c[1:0], pins[2], pins[1], pins[0], sel),
          route(c[1:0], pins[4], pins[3], pins[0], sel)};
        check(o_capture_input, v, "routed inputs");
        check(o_is_output, {3{c == 0}}, "directions");
      end
    end
    @(posedge i_clk);
    {i_ch1_filtered_to_ch1, i_ch3_raw, i_ch4_raw} <= 3'b000;
    for (int d = 0; d < 4; d++) begin
      wr(OFF_CHEN, 16'h0000);
      wr(OFF_CM1, 16'h0001);
      wr(OFF_CM2, {4'h0, d[1:0], 2'b01, 4'h0, d[1:0], 2'b01});
      wr(OFF_CHEN, 16'h1101);
      b1 = n_cap[CH1];
      b3 = n_cap[CH3];
      b4 = n_cap[CH4];
      repeat (16) pulse(3);
      wait_cyc(3);
      check(16'(n_cap[CH3] - b3), 16'(16 >> d), "ch3 capture count");
      check(16'(n_cap[CH4] - b4), 16'(16 >> d), "ch4 capture count");
      check(16'(n_cap[CH1] - b1), 16'h0010, "ch1 capture count");
    end
    // A disable in mid-count must restart the divide-by-eight count
    b3 = n_cap[CH3];
    repeat (5) pulse(3);
    wr(OFF_CHEN, 16'h0000);
    wr(OFF_CHEN, 16'h1100);
    repeat (5) pulse(3);
    wait_cyc(3);
    check(16'(n_cap[CH3] - b3), 16'h0000, "divider count after disable");
    wr(OFF_CHEN, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CM2, (k == 1) ? 16'h00f1 : 16'h0031);
      wr(OFF_CHEN, 16'h0100);
      b3 = n_cap[CH3];
      pulse((k == 1) ? 160 : 5);
      pulse((k == 1) ? 320 : 12);
      wait_cyc((k == 1) ? 320 : 12);
      check(16'(n_cap[CH3] - b3), 16'h0001, "filtered captures");
    end
    wait_cyc(3);
    finish_test();
  end
endmodule
